/* rtl/swwc_ctrl.sv */
// sleep sequencing, status flags, interrupt flags and watchdog control
`timescale 1ns/1ps
module swwc_ctrl (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_we_i,
	input  wire logic       reg_re_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       sleep_instr_i,
	input  wire logic       clear_watchdog_instr_i,
	input  wire logic [1:0] watchdog_mode_field_i,
	input  wire logic [7:0] periph_event_i,
	input  wire logic       timer0_event_i,
	input  wire logic       ioc_event_i,
	input  wire logic       ext_irq_pin_i,
	input  wire logic       external_reset_pin_n_i,
	input  wire logic       brownout_reset_i,
	output logic            cpu_clk_en_o,
	output logic            slow_osc_en_o,
	output logic            asleep_o,
	output logic            resume_o,
	output logic            irq_req_o,
	output logic            device_reset_o
);
	typedef struct packed {
		swwc_pkg::swwc_pwr_t pwr;
		logic [2:0] ext_sync;
		logic [1:0] external_reset_pin_sync;
		logic [1:0] bor_sync;
		logic       timeout_flag;
		logic       powerdown_flag;
		logic [7:0] irq_control;
		logic [7:0] periph_enable;
		logic [7:0] periph_flags;
		logic [4:0] period_select;
		logic       soft_enable;
		logic [7:0] rdata;
		logic       cpu_clk_en;
		logic       slow_osc_en;
		logic       resume;
		logic       irq_req;
		logic       device_reset;
	} swwc_st_t;

	swwc_st_t   st_reg;
	swwc_st_t   st_next;
	swwc_wdt_if wdt ();

	logic       wake_irq;
	logic       any_irq;
	logic       wdt_active;
	logic       ext_edge;
	logic       ext_reset;
	logic [2:0] irq_flags;
	logic [7:0] status_rd;

	swwc_wdt_counter u_wdt (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.wdt    (wdt.counter)
	);

	// per-source pending test; the global enable is deliberately absent
	function automatic logic swwc_pending(
		input logic [7:0] ctl,
		input logic [7:0] pie,
		input logic [7:0] pir
	);
		swwc_pending = |(pie & pir & swwc_pkg::PERIPH_MASK)
			|| (ctl[swwc_pkg::TMR0_IE_BIT] && ctl[swwc_pkg::TMR0_IF_BIT])
			|| (ctl[swwc_pkg::EXT_IE_BIT] && ctl[swwc_pkg::EXT_IF_BIT])
			|| (ctl[swwc_pkg::IOC_IE_BIT] && ctl[swwc_pkg::IOC_IF_BIT]);
	endfunction : swwc_pending

	always_comb begin
		// the edge is taken between the second and third synchroniser stages
		ext_edge  = st_reg.ext_sync[1] && !st_reg.ext_sync[2];
		ext_reset = !st_reg.external_reset_pin_sync[1] || st_reg.bor_sync[1];
		wake_irq = swwc_pending(st_reg.irq_control, st_reg.periph_enable,
			st_reg.periph_flags);
		any_irq = wake_irq && st_reg.irq_control[swwc_pkg::GIE_BIT];
		irq_flags = {timer0_event_i, ext_edge, ioc_event_i};
		status_rd = '0;
		status_rd[swwc_pkg::TIMEOUT_BIT]   = st_reg.timeout_flag;
		status_rd[swwc_pkg::POWERDOWN_BIT] = st_reg.powerdown_flag;
	end

	always_comb begin
		case (swwc_pkg::swwc_wdt_mode_t'(watchdog_mode_field_i))
			swwc_pkg::SWWC_WDT_ALWAYS: wdt_active = 1'b1;
			swwc_pkg::SWWC_WDT_AWAKE:
				wdt_active = st_reg.pwr == swwc_pkg::SWWC_AWAKE;
			swwc_pkg::SWWC_WDT_SOFT:   wdt_active = st_reg.soft_enable;
			default:                   wdt_active = 1'b0;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.ext_sync  = {st_reg.ext_sync[1:0], ext_irq_pin_i};
		st_next.external_reset_pin_sync = {st_reg.external_reset_pin_sync[0], external_reset_pin_n_i};
		st_next.bor_sync  = {st_reg.bor_sync[0], brownout_reset_i};
		st_next.resume = 1'b0;
		st_next.device_reset = 1'b0;
		wdt.clear = clear_watchdog_instr_i;

		// register writes; hardware events are applied afterwards so they win
		if (reg_we_i) begin
			case (reg_addr_i)
				swwc_pkg::REG_IRQ_CONTROL: st_next.irq_control = reg_wdata_i;
				swwc_pkg::REG_PERIPH_ENABLE:
					st_next.periph_enable = reg_wdata_i & swwc_pkg::PERIPH_MASK;
				swwc_pkg::REG_PERIPH_FLAGS:
					st_next.periph_flags = reg_wdata_i & swwc_pkg::PERIPH_MASK;
				swwc_pkg::REG_WDT_CONTROL: begin
					st_next.period_select = reg_wdata_i[swwc_pkg::PERIOD_LSB +:
						swwc_pkg::PERIOD_W];
					st_next.soft_enable = reg_wdata_i[swwc_pkg::SOFT_EN_BIT];
				end
				default: ;
			endcase
		end
		st_next.periph_flags = st_next.periph_flags
			| (periph_event_i & swwc_pkg::PERIPH_MASK);
		st_next.irq_control[swwc_pkg::IOC_IF_BIT +: 3] =
			st_next.irq_control[swwc_pkg::IOC_IF_BIT +: 3] | irq_flags;

		case (st_reg.pwr)
			swwc_pkg::SWWC_AWAKE: begin
				if (sleep_instr_i && !wake_irq) begin
					st_next.pwr = swwc_pkg::SWWC_ENTER;
				end
				if (wdt.timeout) begin
					st_next.device_reset = 1'b1;
					st_next.timeout_flag = 1'b0;
				end
			end
			swwc_pkg::SWWC_ENTER: begin
				wdt.clear = 1'b1;
				st_next.powerdown_flag = 1'b0;
				st_next.timeout_flag   = 1'b1;
				st_next.cpu_clk_en = 1'b0;
				st_next.pwr = wake_irq ? swwc_pkg::SWWC_WAKE
					: swwc_pkg::SWWC_ASLEEP;
			end
			swwc_pkg::SWWC_ASLEEP: begin
				if (wake_irq) begin
					st_next.pwr = swwc_pkg::SWWC_WAKE;
				end else if (wdt.timeout) begin
					st_next.timeout_flag   = 1'b0;
					st_next.powerdown_flag = 1'b0;
					st_next.pwr = swwc_pkg::SWWC_WAKE;
				end
			end
			swwc_pkg::SWWC_WAKE: begin
				wdt.clear = 1'b1;
				st_next.cpu_clk_en = 1'b1;
				st_next.resume = 1'b1;
				st_next.pwr = swwc_pkg::SWWC_AWAKE;
			end
			default: st_next.pwr = swwc_pkg::SWWC_AWAKE;
		endcase

		// pin and brownout reset the device
		if (ext_reset) begin
			st_next.device_reset = 1'b1;
			st_next.cpu_clk_en = 1'b1;
			st_next.pwr = swwc_pkg::SWWC_AWAKE;
		end
		st_next.irq_req = any_irq && st_next.cpu_clk_en;
		st_next.slow_osc_en = 1'b1;

		st_next.rdata = '0;
		if (reg_re_i) begin
			case (reg_addr_i)
				swwc_pkg::REG_CORE_STATUS:   st_next.rdata = status_rd;
				swwc_pkg::REG_IRQ_CONTROL:   st_next.rdata = st_reg.irq_control;
				swwc_pkg::REG_PERIPH_ENABLE: st_next.rdata = st_reg.periph_enable;
				swwc_pkg::REG_PERIPH_FLAGS:  st_next.rdata = st_reg.periph_flags;
				swwc_pkg::REG_WDT_CONTROL:
					st_next.rdata = {2'h0, st_reg.period_select, st_reg.soft_enable};
				default:                     st_next.rdata = '0;
			endcase
		end
	end

	assign wdt.active = wdt_active;
	assign wdt.period = st_reg.period_select;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.pwr <= swwc_pkg::SWWC_AWAKE;
			st_reg.external_reset_pin_sync <= 2'h3;
			st_reg.timeout_flag <= 1'b1;
			st_reg.powerdown_flag <= 1'b1;
			st_reg.irq_control <= swwc_pkg::IRQ_CONTROL_RST;
			st_reg.periph_enable <= swwc_pkg::PERIPH_RST;
			st_reg.periph_flags <= swwc_pkg::PERIPH_RST;
			st_reg.period_select <= swwc_pkg::PERIOD_RST;
			st_reg.soft_enable <= swwc_pkg::SOFT_EN_RST;
			st_reg.cpu_clk_en <= 1'b1;
			st_reg.slow_osc_en <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o    = st_reg.rdata;
	assign cpu_clk_en_o   = st_reg.cpu_clk_en;
	assign slow_osc_en_o  = st_reg.slow_osc_en;
	assign asleep_o       = !st_reg.cpu_clk_en;
	assign resume_o       = st_reg.resume;
	assign irq_req_o      = st_reg.irq_req;
	assign device_reset_o = st_reg.device_reset;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_event_sets_flag: assert property (
		periph_event_i[1] |=> st_reg.periph_flags[1])
		else $error("peripheral flag not set by event");
	a_sleep_nop: assert property (
		st_reg.pwr == swwc_pkg::SWWC_AWAKE && sleep_instr_i && wake_irq
		&& !ext_reset |=> st_reg.pwr == swwc_pkg::SWWC_AWAKE
		&& $stable(st_reg.powerdown_flag))
		else $error("sleep not treated as nop");
	a_entry_flags: assert property (
		st_reg.pwr == swwc_pkg::SWWC_ENTER |=> !st_reg.powerdown_flag
		&& st_reg.timeout_flag && !cpu_clk_en_o)
		else $error("entry flags wrong");
	a_clock_gated: assert property (
		st_reg.pwr == swwc_pkg::SWWC_ASLEEP |-> !cpu_clk_en_o)
		else $error("cpu clock running in sleep");
	a_osc_running: assert property (
		##1 slow_osc_en_o)
		else $error("slow oscillator stopped");
	a_late_irq_wakes: assert property (
		st_reg.pwr == swwc_pkg::SWWC_ENTER && wake_irq && !ext_reset
		|=> st_reg.pwr == swwc_pkg::SWWC_WAKE ##1 resume_o)
		else $error("late interrupt did not wake at once");
	a_wake_clears: assert property (
		st_reg.pwr == swwc_pkg::SWWC_WAKE |-> wdt.clear)
		else $error("wake did not clear watchdog");
	a_awake_timeout: assert property (
		st_reg.pwr == swwc_pkg::SWWC_AWAKE && wdt.timeout |=> device_reset_o)
		else $error("awake timeout without reset");
	a_sleep_timeout: assert property (
		st_reg.pwr == swwc_pkg::SWWC_ASLEEP && wdt.timeout && !wake_irq
		&& !ext_reset |=> !device_reset_o && !st_reg.timeout_flag
		##1 resume_o)
		else $error("sleep timeout did not resume");
	a_mode_off: assert property (
		watchdog_mode_field_i == 2'h0 |-> !wdt.active)
		else $error("watchdog active in mode 00");
	a_awake_mode: assert property (
		watchdog_mode_field_i == 2'h2 && st_reg.pwr == swwc_pkg::SWWC_ASLEEP
		|-> !wdt.active)
		else $error("watchdog active asleep in mode 10");
	a_soft_mode: assert property (
		watchdog_mode_field_i == 2'h1 |-> wdt.active == st_reg.soft_enable)
		else $error("soft mode not following enable");

	c_sleep_entry: cover property (st_reg.pwr == swwc_pkg::SWWC_ASLEEP);
	c_irq_wake: cover property (
		st_reg.pwr == swwc_pkg::SWWC_ASLEEP && wake_irq);
	c_sleep_nop: cover property (sleep_instr_i && wake_irq);
	c_wdt_wake: cover property (
		st_reg.pwr == swwc_pkg::SWWC_ASLEEP && wdt.timeout);
endmodule : swwc_ctrl

/* rtl/swwc_pkg.sv */
// shared constants and types for the sleep and watchdog controller
package swwc_pkg;
	// register indices on the plain register port
	localparam logic [2:0] REG_CORE_STATUS   = 3'h0;
	localparam logic [2:0] REG_IRQ_CONTROL   = 3'h1;
	localparam logic [2:0] REG_PERIPH_ENABLE = 3'h2;
	localparam logic [2:0] REG_PERIPH_FLAGS  = 3'h3;
	localparam logic [2:0] REG_WDT_CONTROL   = 3'h4;

	// core_status fields
	localparam int TIMEOUT_BIT   = 4;
	localparam int POWERDOWN_BIT = 3;
	// interrupt_control fields
	localparam int GIE_BIT       = 7;
	localparam int PERIPHERAL_IRQ_GATE_BIT      = 6;
	localparam int TMR0_IE_BIT   = 5;
	localparam int EXT_IE_BIT    = 4;
	localparam int IOC_IE_BIT    = 3;
	localparam int TMR0_IF_BIT   = 2;
	localparam int EXT_IF_BIT    = 1;
	localparam int IOC_IF_BIT    = 0;
	// watchdog_control fields
	localparam int PERIOD_LSB    = 1;
	localparam int PERIOD_W      = 5;
	localparam int SOFT_EN_BIT   = 0;

	// implemented peripheral enable and flag bits, and implemented watchdog_control bits
	localparam logic [7:0] PERIPH_MASK   = 8'h5A;
	localparam logic [7:0] WDT_CTRL_MASK = 8'h3F;

	// reset values
	localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
	localparam logic [7:0] PERIPH_RST      = 8'h00;
	// period select 01011 gives 1:65536, nominal two seconds
	localparam logic [4:0] PERIOD_RST      = 5'h0B;
	localparam logic       SOFT_EN_RST     = 1'b0;

	// period select limits
	localparam logic [4:0] PERIOD_MAX      = 5'h12;
	localparam int         PRESCALE_BASE   = 5;
	localparam int         WDT_CNT_W       = 24;

	// timing: slow oscillator tick derived from the core clock
	localparam longint CLK_HZ          = 125000000;
	localparam longint SLOW_OSC_HZ     = 31000;
	localparam int     SLOW_TICK_CYC   = int'(CLK_HZ / SLOW_OSC_HZ);
	localparam int     SLOW_DIV_W      = 12;

	// watchdog modes from the configuration word
	typedef enum logic [1:0] {
		SWWC_WDT_OFF    = 2'h0,
		SWWC_WDT_SOFT   = 2'h1,
		SWWC_WDT_AWAKE  = 2'h2,
		SWWC_WDT_ALWAYS = 2'h3
	} swwc_wdt_mode_t;

	// power states, gray coded along awake, enter, asleep, wake
	typedef enum logic [1:0] {
		SWWC_AWAKE  = 2'h0,
		SWWC_ENTER  = 2'h1,
		SWWC_ASLEEP = 2'h3,
		SWWC_WAKE   = 2'h2
	} swwc_pwr_t;
endpackage : swwc_pkg

/* rtl/swwc_wdt_counter.sv */
// watchdog counter clocked by slow oscillator ticks
`timescale 1ns/1ps
module swwc_wdt_counter (
	input  wire logic    mclk_i,
	input  wire logic    rst_i,
	swwc_wdt_if.counter  wdt
);
	typedef struct packed {
		logic [swwc_pkg::SLOW_DIV_W-1:0] div;
		logic                            tick;
		logic [swwc_pkg::WDT_CNT_W-1:0]  count;
		logic                            timeout;
	} swwc_cnt_st_t;

	swwc_cnt_st_t st_reg;
	swwc_cnt_st_t st_next;

	// out-of-range period codes fall back to the shortest interval
	function automatic logic [swwc_pkg::WDT_CNT_W-1:0] swwc_limit(
		input logic [swwc_pkg::PERIOD_W-1:0] ps
	);
		logic [4:0] sh;
		sh = (ps > swwc_pkg::PERIOD_MAX) ? 5'h00 : ps;
		swwc_limit = swwc_pkg::WDT_CNT_W'(1) << (sh + 5'(swwc_pkg::PRESCALE_BASE));
	endfunction : swwc_limit

	always_comb begin
		st_next = st_reg;
		st_next.timeout = 1'b0;
		st_next.tick = 1'b0;
		if (st_reg.div == swwc_pkg::SLOW_DIV_W'(swwc_pkg::SLOW_TICK_CYC - 1)) begin
			st_next.div = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.div = st_reg.div + 1'b1;
		end
		if (wdt.clear || !wdt.active) begin
			st_next.count = '0;
		end else if (st_reg.tick) begin
			// period 1 ms to 256 s
			if (st_reg.count == swwc_limit(wdt.period) - 1'b1) begin
				st_next.count = '0;
				st_next.timeout = 1'b1;
			end else begin
				st_next.count = st_reg.count + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wdt.timeout = st_reg.timeout;
	assign wdt.busy    = (st_reg.count != '0);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_count_clear: assert property (
		wdt.clear |=> st_reg.count == '0)
		else $error("watchdog count not cleared");
	a_timeout_cause: assert property (
		st_reg.timeout |-> $past(st_reg.tick) && $past(wdt.active)
		&& !$past(wdt.clear))
		else $error("timeout without a counting tick");
	a_tick_spacing: assert property (
		st_reg.tick |=> !st_reg.tick [*8])
		else $error("slow ticks too close");
	c_timeout: cover property (st_reg.timeout);
endmodule : swwc_wdt_counter

/* rtl/swwc_wdt_if.sv */
// link between the power controller and the watchdog counter
`timescale 1ns/1ps
interface swwc_wdt_if;
	logic                          clear;
	logic                          active;
	logic [swwc_pkg::PERIOD_W-1:0] period;
	logic                          timeout;
	logic                          busy;

	modport ctrl (
		output clear,
		output active,
		output period,
		input  timeout,
		input  busy
	);
	modport counter (
		input  clear,
		input  active,
		input  period,
		output timeout,
		output busy
	);
endinterface : swwc_wdt_if

/* sim/sleep_wake_watchdog_ctrl_tb.sv */
// self-checking bench for the sleep and watchdog controller
`timescale 1ns/1ps
module sleep_wake_watchdog_ctrl_tb;
	logic       mclk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [2:0] reg_addr_i = 3'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_we_i = 1'b0;
	logic       reg_re_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic       sleep_instr_i;
	logic       clear_watchdog_instr_i;
	logic [1:0] watchdog_mode_field_i = 2'h1;
	logic [7:0] periph_event_i = 8'h00;
	logic       timer0_event_i = 1'b0;
	logic       ioc_event_i = 1'b0;
	logic       ext_irq_pin_i = 1'b0;
	logic       external_reset_pin_n_i = 1'b1;
	logic       brownout_reset_i = 1'b0;
	logic       cpu_clk_en_o;
	logic       slow_osc_en_o;
	logic       asleep_o;
	logic       resume_o;
	logic       irq_req_o;
	logic       device_reset_o;
	int         failures = 0;
	int         tests_run = 0;
	int         cycles = 0;

	swwc_ctrl dut_u (
		.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
		.reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.sleep_instr_i(sleep_instr_i),
		.clear_watchdog_instr_i(clear_watchdog_instr_i),
		.watchdog_mode_field_i(watchdog_mode_field_i),
		.periph_event_i(periph_event_i), .timer0_event_i(timer0_event_i),
		.ioc_event_i(ioc_event_i), .ext_irq_pin_i(ext_irq_pin_i),
		.external_reset_pin_n_i(external_reset_pin_n_i),
		.brownout_reset_i(brownout_reset_i), .cpu_clk_en_o(cpu_clk_en_o),
		.slow_osc_en_o(slow_osc_en_o), .asleep_o(asleep_o),
		.resume_o(resume_o), .irq_req_o(irq_req_o),
		.device_reset_o(device_reset_o)
	);

	swwc_cpu_model cpu_u (
		.mclk_i(mclk_i), .cpu_clk_en_i(cpu_clk_en_o),
		.sleep_instr_o(sleep_instr_i),
		.clear_watchdog_instr_o(clear_watchdog_instr_i)
	);

	initial begin
		forever #4 mclk_i = ~mclk_i;
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// whole run needs well under a thousand cycles
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			complete_run();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic nap(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : nap

	task automatic do_reset;
		@(posedge mclk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
	endtask : do_reset

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_we_i    <= 1'b1;
		@(posedge mclk_i);
		reg_we_i    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge mclk_i);
		reg_re_i   <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask : rdchk

	task automatic evt(input logic [7:0] p, input logic t, input logic i);
		@(posedge mclk_i);
		periph_event_i <= p;
		timer0_event_i <= t;
		ioc_event_i    <= i;
		@(posedge mclk_i);
		periph_event_i <= 8'h00;
		timer0_event_i <= 1'b0;
		ioc_event_i    <= 1'b0;
	endtask : evt

	// resume stands one cycle, so look after every edge
	task automatic wait_resume;
		int n;
		n = 0;
		while (resume_o !== 1'b1 && n < 20) begin
			@(posedge mclk_i);
			#1 n++;
		end
		chk(resume_o, 8'h01);
		chk(cpu_clk_en_o, 8'h01);
	endtask : wait_resume

	task automatic t_defaults;
		rdchk(swwc_pkg::REG_WDT_CONTROL, 8'h16);
		rdchk(3'h5, 8'h00);
		chk(slow_osc_en_o, 8'h01);
	endtask : t_defaults

	task automatic t_flags;
		evt(8'hFF, 1'b1, 1'b1);
		rdchk(swwc_pkg::REG_PERIPH_FLAGS, 8'h5A);
		ext_irq_pin_i <= 1'b1;
		nap(6);
		rdchk(swwc_pkg::REG_IRQ_CONTROL, 8'h07);
		chk(irq_req_o, 8'h00);
		ext_irq_pin_i <= 1'b0;
		// software clears flags before it enables a source
		wr(swwc_pkg::REG_PERIPH_FLAGS, 8'h00);
		wr(swwc_pkg::REG_IRQ_CONTROL, 8'h00);
		rdchk(swwc_pkg::REG_PERIPH_FLAGS, 8'h00);
	endtask : t_flags

	task automatic t_nop_sleep;
		wr(swwc_pkg::REG_IRQ_CONTROL, 8'h08);
		evt(8'h00, 1'b0, 1'b1);
		cpu_u.issue(1'b1);
		nap(4);
		chk(cpu_clk_en_o, 8'h01);
		rdchk(swwc_pkg::REG_CORE_STATUS, 8'h18);
		wr(swwc_pkg::REG_IRQ_CONTROL, 8'h00);
	endtask : t_nop_sleep

	task automatic t_sleep_wake;
		wr(swwc_pkg::REG_WDT_CONTROL, 8'h17);
		wr(swwc_pkg::REG_PERIPH_ENABLE, 8'h02);
		wr(swwc_pkg::REG_IRQ_CONTROL, 8'h80);
		cpu_u.issue(1'b0);
		cpu_u.issue(1'b1);
		nap(3);
		chk(cpu_clk_en_o, 8'h00);
		chk(asleep_o, 8'h01);
		chk(slow_osc_en_o, 8'h01);
		rdchk(swwc_pkg::REG_CORE_STATUS, 8'h10);
		evt(8'h40, 1'b0, 1'b1);
		nap(6);
		chk(asleep_o, 8'h01);
		evt(8'h02, 1'b0, 1'b0);
		wait_resume();
		nap(2);
		chk(irq_req_o, 8'h01);
		wr(swwc_pkg::REG_PERIPH_FLAGS, 8'h00);
		wr(swwc_pkg::REG_IRQ_CONTROL, 8'h00);
	endtask : t_sleep_wake

	task automatic t_late_irq;
		do_reset();
		wr(swwc_pkg::REG_PERIPH_ENABLE, 8'h02);
		// event lands on the sleep edge, so the flag is seen during entry
		fork
			cpu_u.issue(1'b1);
			begin
				@(posedge sleep_instr_i);
				periph_event_i <= 8'h02;
				@(posedge mclk_i);
				periph_event_i <= 8'h00;
			end
		join
		wait_resume();
		rdchk(swwc_pkg::REG_CORE_STATUS, 8'h10);
		chk(irq_req_o, 8'h00);
		wr(swwc_pkg::REG_PERIPH_FLAGS, 8'h00);
		wr(swwc_pkg::REG_PERIPH_ENABLE, 8'h00);
	endtask : t_late_irq

	// awake-only mode through one sleep and wake, then off and always-on modes while awake
	task automatic t_modes;
		watchdog_mode_field_i <= 2'h2;
		wr(swwc_pkg::REG_PERIPH_ENABLE, 8'h02);
		cpu_u.issue(1'b1);
		nap(3);
		chk(asleep_o, 8'h01);
		evt(8'h02, 1'b0, 1'b0);
		wait_resume();
		rdchk(swwc_pkg::REG_CORE_STATUS, 8'h10);
		watchdog_mode_field_i <= 2'h0;
		nap(2);
		chk(cpu_clk_en_o, 8'h01);
		watchdog_mode_field_i <= 2'h3;
		wr(swwc_pkg::REG_PERIPH_FLAGS, 8'h00);
		wr(swwc_pkg::REG_PERIPH_ENABLE, 8'h00);
		chk(device_reset_o, 8'h00);
		watchdog_mode_field_i <= 2'h1;
	endtask : t_modes

	task automatic t_resets;
		cpu_u.issue(1'b1);
		nap(3);
		chk(asleep_o, 8'h01);
		brownout_reset_i <= 1'b1;
		nap(4);
		chk(device_reset_o, 8'h01);
		brownout_reset_i <= 1'b0;
		nap(5);
		chk(device_reset_o, 8'h00);
		chk(asleep_o, 8'h00);
		external_reset_pin_n_i <= 1'b0;
		nap(4);
		chk(device_reset_o, 8'h01);
		external_reset_pin_n_i <= 1'b1;
		nap(5);
		chk(device_reset_o, 8'h00);
	endtask : t_resets

	initial begin
		do_reset();
		t_defaults();
		t_flags();
		t_nop_sleep();
		t_sleep_wake();
		t_late_irq();
		t_modes();
		t_resets();
		complete_run();
	end
endmodule : sleep_wake_watchdog_ctrl_tb

/* sim/swwc_cpu_model.sv */
// cpu core stand-in that issues sleep and watchdog clear instructions
`timescale 1ns/1ps
module swwc_cpu_model (
	input  wire logic mclk_i,
	input  wire logic cpu_clk_en_i,
	output logic      sleep_instr_o,
	output logic      clear_watchdog_instr_o
);
	initial begin
		sleep_instr_o = 1'b0;
		clear_watchdog_instr_o = 1'b0;
	end

	// a halted core executes nothing, so it waits for its clock
	task automatic issue(input logic is_sleep);
		@(posedge mclk_i);
		while (cpu_clk_en_i !== 1'b1) @(posedge mclk_i);
		if (is_sleep) sleep_instr_o <= 1'b1;
		else clear_watchdog_instr_o <= 1'b1;
		@(posedge mclk_i);
		sleep_instr_o <= 1'b0;
		clear_watchdog_instr_o <= 1'b0;
	endtask : issue
endmodule : swwc_cpu_model
